// ===== rtl/wake_timer.sv
// Purpose: 32-bit wake-up timer with compare points, auto interval and AXI4-Lite registers
// Assumes: Oscillator and external clock arrive as slow pins sampled on clock
// Notes:   One clock domain; slow clocks become tick enables after synchronising
// Function
// RULE1: Clock source picked by two select bits
// RULE2: Prescaler divides by 1, 16, 256, 32768
// RULE3: Peripheral clock with ratio code 00 divides four
// RULE4: Counter keeps running while peripheral clock off
// RULE5: Free mode counts to all ones, wraps
// RULE6: Periodic mode restarts after matching compare D
// RULE7: Four compare values each raise a flag
// RULE8: Enable starts counting; clearing stops and zeroes
// RULE9: Count read as two 16-bit halves
// RULE10: Freeze holds high half between split reads
// RULE11: Interval write loads compare A bits 16:5
// RULE12: Compare A match adds interval times 32
// RULE13: Advanced compare A wraps by subtracting limit
// RULE14: Stop bit blocks compare A updates
// RULE15: Software brackets interval writes with stop bit
// RULE16: Software masks B/C interrupt while rewriting
// RULE17: Compare D rewrite restrictions per mode
// RULE18: Software configures compares before enabling timer
// RULE19: Interrupt on compare match or full scale
// RULE20: Five flags, enable mask, write-one clear
// RULE21: Oscillator clock: clear lands after two edges
// RULE22: Status bit 6 shows clear in progress
// RULE23: Select 00 peripheral, 01/10 oscillator, 11 external
// RULE24: Mode bit 0 periodic, 1 free, default free
// RULE25: Ratio codes 00/01/10/11 map to 1/16/256/32768
// RULE26: Single interrupt output from enabled pending flags
// RULE27: Slow clock inputs synchronised in hardware
module wake_timer
    import wake_timer_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                clock_enable,
    // Clock sources
    input  wire logic                pclk_on,
    input  wire logic                low_freq_osc,
    input  wire logic                external_clock_pin,
    // Register bus
    input  wire wake_timer_pkg::axi_req_s bus_req,
    output      wake_timer_pkg::axi_rsp_s bus_rsp,
    // Interrupt
    output      logic                irq
);
    import wake_timer_pkg::*;

    state_s            st;            // Registered state
    state_s            next_st;       // Next state
    logic              osc_rise;      // Oscillator rising edge seen
    logic              ext_rise;      // External clock rising edge seen
    logic              src_tick;      // Selected source edge
    logic              tick;          // Prescaled counter advance
    logic [14:0]       term;          // Prescaler terminal count
    logic [IRQ_N-1:0]  evt;           // Events in this cycle
    logic [IRQ_N-1:0]  apply_clear;   // Flags being cleared now
    logic [32:0]       sum_a;         // Advanced compare A, with carry
    logic [32:0]       wrap_a;        // Advanced compare A after wrap
    logic [31:0]       limit;         // Count limit of the mode
    logic              free_mode;     // Free-running selected
    logic              osc_sel;       // Oscillator is the source
    logic              aw_hs;         // Write address taken
    logic              w_hs;          // Write data taken
    logic              ar_hs;         // Read address taken
    logic              do_write;      // Write performed this cycle
    logic [15:0]       wval;          // Write data merged with strobes
    logic [15:0]       old16;         // Present value of the write target
    logic [15:0]       rval;          // Read data of the decoded register
    logic              rmap;          // Read address is mapped
    logic              wmap;          // Write address is mapped

    // Merge low two byte lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // Ready outputs gate with the clock enable so nothing moves while frozen
    assign bus_rsp.awready = clock_enable & ~st.aw_got & ~st.bvalid;
    assign bus_rsp.wready  = clock_enable & ~st.w_got & ~st.bvalid;
    assign bus_rsp.arready = clock_enable & ~st.rvalid;
    assign bus_rsp.bvalid  = st.bvalid;
    assign bus_rsp.bresp   = st.bresp;
    assign bus_rsp.rvalid  = st.rvalid;
    assign bus_rsp.rdata   = st.rdata;
    assign bus_rsp.rresp   = st.rresp;
    assign irq             = st.irq;

    // Handshakes of this cycle
    assign aw_hs = bus_req.awvalid & bus_rsp.awready;
    assign w_hs  = bus_req.wvalid & bus_rsp.wready;
    assign ar_hs = bus_req.arvalid & bus_rsp.arready;

    // Mode decodes
    assign free_mode = st.control[CTL_MODE];                         // [RULE24]
    assign osc_sel   = (st.control[CTL_CLK_LSB +: 2] == CLK_OSC_A) ||
                       (st.control[CTL_CLK_LSB +: 2] == CLK_OSC_B);   // [RULE23]
    assign limit     = free_mode ? ALL_ONES : st.cmp_d;

    // Edge detect on the second synchroniser stage only
    assign osc_rise = st.osc_sync & ~st.osc_prev;
    assign ext_rise = st.ext_sync & ~st.ext_prev;

    // Source pick
    always_comb begin
        unique case (st.control[CTL_CLK_LSB +: 2])                   // [RULE1] [RULE23]
            CLK_PERIPH: begin
                src_tick = pclk_on;                                 // Gated peripheral clock
            end
            CLK_OSC_A, CLK_OSC_B: begin
                src_tick = osc_rise;                                // [RULE4] Runs without pclk
            end
            default: begin
                src_tick = ext_rise;                                // [RULE4] Runs without pclk
            end
        endcase
    end

    // Prescaler ratio pick
    always_comb begin
        unique case (st.control[CTL_PRE_LSB +: 2])                   // [RULE2] [RULE25]
            PRE_DIV1: begin
                // Peripheral clock is too fast to count raw
                term = (st.control[CTL_CLK_LSB +: 2] == CLK_PERIPH) ? TERM_DIV4 : TERM_DIV1; // [RULE3]
            end
            PRE_DIV16: begin
                term = TERM_DIV16;
            end
            PRE_DIV256: begin
                term = TERM_DIV256;
            end
            default: begin
                term = divide_by_32768;
            end
        endcase
    end

    // Register decode for reads
    always_comb begin
        rval = 16'h0000;
        rmap = 1'b1;
        unique case (bus_req.araddr)
            OFF_COUNT_LOW:  rval = st.count[15:0];                   // [RULE9]
            OFF_COUNT_HIGH: rval = st.frozen ? st.high_hold : st.count[31:16]; // [RULE9] [RULE10]
            OFF_CONTROL:    rval = st.control & CTL_WRITE_MASK;
            OFF_INTERVAL:   rval = {4'h0, st.interval};
            OFF_CMP_B_LOW:  rval = st.cmp_b[15:0];
            OFF_CMP_B_HIGH: rval = st.cmp_b[31:16];
            OFF_CMP_C_LOW:  rval = st.cmp_c[15:0];
            OFF_CMP_C_HIGH: rval = st.cmp_c[31:16];
            OFF_CMP_D_LOW:  rval = st.cmp_d[15:0];
            OFF_CMP_D_HIGH: rval = st.cmp_d[31:16];
            OFF_IRQ_ENABLE: rval = {11'h000, st.irq_en};
            OFF_STATUS:     rval = {9'h000, st.clr_busy, 1'b0, st.irq_flag}; // [RULE22]
            OFF_IRQ_CLEAR:  rval = 16'h0000;                         // Write only, reads zero
            OFF_CMP_A_LOW:  rval = st.cmp_a[15:0];
            OFF_CMP_A_HIGH: rval = st.cmp_a[31:16];
            default:        rmap = 1'b0;
        endcase
    end

    // Present value of the write target, for byte-lane merging
    always_comb begin
        old16 = 16'h0000;
        wmap  = 1'b1;
        unique case (st.aw_addr)
            OFF_CONTROL:    old16 = st.control;
            OFF_INTERVAL:   old16 = {4'h0, st.interval};
            OFF_CMP_B_LOW:  old16 = st.cmp_b[15:0];
            OFF_CMP_B_HIGH: old16 = st.cmp_b[31:16];
            OFF_CMP_C_LOW:  old16 = st.cmp_c[15:0];
            OFF_CMP_C_HIGH: old16 = st.cmp_c[31:16];
            OFF_CMP_D_LOW:  old16 = st.cmp_d[15:0];
            OFF_CMP_D_HIGH: old16 = st.cmp_d[31:16];
            OFF_IRQ_ENABLE: old16 = {11'h000, st.irq_en};
            OFF_IRQ_CLEAR:  old16 = 16'h0000;
            default:        wmap  = 1'b0;                           // Read-only or unmapped
        endcase
    end

    assign wval     = merge16(old16, st.w_data, st.w_strb);
    assign do_write = st.aw_got & st.w_got & ~st.bvalid;

    // Next-state logic for the whole block
    always_comb begin
        next_st     = st;
        tick        = 1'b0;
        evt         = '0;
        apply_clear = '0;
        sum_a       = 33'h0;
        wrap_a      = 33'h0;

        // Two-stage synchronisers, first stage feeds only the second
        next_st.osc_meta = low_freq_osc;                             // [RULE27]
        next_st.osc_sync = st.osc_meta;                              // [RULE27]
        next_st.osc_prev = st.osc_sync;
        next_st.ext_meta = external_clock_pin;                       // [RULE27]
        next_st.ext_sync = st.ext_meta;                              // [RULE27]
        next_st.ext_prev = st.ext_sync;

        // Prescaler, advancing only while enabled
        if (st.control[CTL_ENABLE] && src_tick) begin                // [RULE8] [RULE18]
            if (st.pre_count >= term) begin                          // [RULE2]
                next_st.pre_count = 15'h0000;
                tick              = 1'b1;
            end else begin
                next_st.pre_count = st.pre_count + 15'h0001;
            end
        end

        // Compare and count on each prescaled tick
        if (tick) begin
            evt[IRQ_A]    = (st.count == st.cmp_a);                  // [RULE7] [RULE19]
            evt[IRQ_B]    = (st.count == st.cmp_b);                  // [RULE7] [RULE19]
            evt[IRQ_C]    = (st.count == st.cmp_c);                  // [RULE7] [RULE19]
            evt[IRQ_D]    = (st.count == st.cmp_d);                  // [RULE7] [RULE19]
            evt[IRQ_FULL] = free_mode && (st.count == ALL_ONES);     // [RULE19]
            if (!free_mode && (st.count == st.cmp_d)) begin
                next_st.count = 32'h0000_0000;                       // [RULE6]
            end else begin
                next_st.count = st.count + 32'h0000_0001;            // [RULE5] Natural wrap
            end
        end

        // Compare A auto advance, held off by the stop bit
        if (evt[IRQ_A] && !st.control[CTL_STOP_INC]) begin           // [RULE14]
            sum_a  = {1'b0, st.cmp_a} + {16'h0000, st.interval, 5'h00}; // [RULE12]
            wrap_a = sum_a - {1'b0, limit};
            // Past the limit the compare point folds back into the count range
            next_st.cmp_a = (sum_a > {1'b0, limit}) ? wrap_a[31:0] : sum_a[31:0]; // [RULE13]
        end

        // Disabled timer holds zero
        if (!st.control[CTL_ENABLE]) begin
            next_st.count     = 32'h0000_0000;                       // [RULE8]
            next_st.pre_count = 15'h0000;
        end

        // Pending interrupt clear waits for oscillator edges
        if (st.clr_busy) begin
            if (!osc_sel) begin
                // Source changed away; no edges to wait for
                apply_clear       = st.clr_pend;
                next_st.clr_pend  = '0;
                next_st.clr_busy  = 1'b0;
                next_st.clr_edges = 2'h0;
            end else if (osc_rise) begin
                if (st.clr_edges + 2'h1 >= CLR_OSC_EDGES) begin      // [RULE21]
                    apply_clear       = st.clr_pend;
                    next_st.clr_pend  = '0;
                    next_st.clr_busy  = 1'b0;                        // [RULE22]
                    next_st.clr_edges = 2'h0;
                end else begin
                    next_st.clr_edges = st.clr_edges + 2'h1;
                end
            end
        end

        // Write address and data are captured independently
        if (aw_hs) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = bus_req.awaddr;
        end
        if (w_hs) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = bus_req.wdata;
            next_st.w_strb = bus_req.wstrb;
        end

        // Perform the write once both halves are held
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = wmap ? RESP_OKAY : RESP_SLVERR;
            unique case (st.aw_addr)
                OFF_CONTROL: begin
                    next_st.control = wval & CTL_WRITE_MASK;         // [RULE1] [RULE8] [RULE24]
                end
                OFF_INTERVAL: begin
                    next_st.interval = wval[11:0];
                    // With the stop bit set the new interval waits for the first A match after the stop bit clears
                    if (!st.control[CTL_STOP_INC]) begin             // [RULE14]
                        next_st.cmp_a[16:5] = wval[11:0];            // [RULE11]
                    end
                end
                OFF_CMP_B_LOW:  next_st.cmp_b[15:0]  = wval;
                OFF_CMP_B_HIGH: next_st.cmp_b[31:16] = wval;
                OFF_CMP_C_LOW:  next_st.cmp_c[15:0]  = wval;
                OFF_CMP_C_HIGH: next_st.cmp_c[31:16] = wval;
                OFF_CMP_D_LOW:  next_st.cmp_d[15:0]  = wval;
                OFF_CMP_D_HIGH: next_st.cmp_d[31:16] = wval;
                OFF_IRQ_ENABLE: next_st.irq_en = wval[IRQ_N-1:0];   // [RULE20]
                OFF_IRQ_CLEAR: begin
                    if (osc_sel) begin
                        next_st.clr_pend  = next_st.clr_pend | wval[IRQ_N-1:0]; // [RULE21]
                        next_st.clr_busy  = next_st.clr_busy | (|wval[IRQ_N-1:0]); // [RULE22]
                        next_st.clr_edges = 2'h0;
                    end else begin
                        apply_clear = apply_clear | wval[IRQ_N-1:0]; // [RULE20]
                    end
                end
                default: begin
                    // Read-only or unmapped: nothing stored
                end
            endcase
        end

        // Write response leaves when the master takes it
        if (st.bvalid && bus_req.bready && clock_enable) begin
            next_st.bvalid = 1'b0;
        end

        // Read capture with the split-read freeze side effect
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = {16'h0000, rval};
            next_st.rresp  = rmap ? RESP_OKAY : RESP_SLVERR;
            if (bus_req.araddr == OFF_COUNT_LOW && st.control[CTL_FREEZE]) begin
                next_st.high_hold = st.count[31:16];                 // [RULE10]
                next_st.frozen    = 1'b1;
            end
            if (bus_req.araddr == OFF_COUNT_HIGH) begin
                next_st.frozen = 1'b0;                               // [RULE10]
            end
        end else if (st.rvalid && bus_req.rready && clock_enable) begin
            next_st.rvalid = 1'b0;
        end

        // A new event beats a clear of the same flag
        next_st.irq_flag = (st.irq_flag & ~apply_clear) | evt;       // [RULE20] [RULE19]

        // One interrupt line from enabled pending flags
        next_st.irq = |(next_st.irq_flag & next_st.irq_en);          // [RULE26]
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= STATE_RESET;
        end else if (clock_enable) begin
            st <= next_st;
        end
    end

endmodule : wake_timer

// ===== rtl/wake_timer_pkg.sv
// Purpose: Shared constants, bus carriers and state layout for the wake-up timer
// Assumes: AXI4-Lite slave with 32-bit data and byte offsets inside an 8-bit window
// Notes:   All registers are 16 bits wide and sit in the low half of each word
package wake_timer_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_COUNT_LOW   = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH  = 8'h04;
    localparam logic [7:0] OFF_CONTROL     = 8'h08;
    localparam logic [7:0] OFF_INTERVAL    = 8'h0C;
    localparam logic [7:0] OFF_CMP_B_LOW   = 8'h10;
    localparam logic [7:0] OFF_CMP_B_HIGH  = 8'h14;
    localparam logic [7:0] OFF_CMP_C_LOW   = 8'h18;
    localparam logic [7:0] OFF_CMP_C_HIGH  = 8'h1C;
    localparam logic [7:0] OFF_CMP_D_LOW   = 8'h20;
    localparam logic [7:0] OFF_CMP_D_HIGH  = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h28;
    localparam logic [7:0] OFF_STATUS      = 8'h2C;
    localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h30;
    localparam logic [7:0] OFF_CMP_A_LOW   = 8'h3C;
    localparam logic [7:0] OFF_CMP_A_HIGH  = 8'h40;

    // Control field positions
    localparam int CTL_PRE_LSB   = 0;
    localparam int CTL_FREEZE    = 3;
    localparam int CTL_MODE      = 6;
    localparam int CTL_ENABLE    = 7;
    localparam int CTL_WAKE_EN   = 8;
    localparam int CTL_CLK_LSB   = 9;
    localparam int CTL_STOP_INC  = 11;
    localparam logic [15:0] CTL_WRITE_MASK = 16'h0FCB;

    // Clock select and prescaler codes
    localparam logic [1:0] CLK_PERIPH   = 2'h0;
    localparam logic [1:0] CLK_OSC_A    = 2'h1;
    localparam logic [1:0] CLK_OSC_B    = 2'h2;
    localparam logic [1:0] CLK_EXT      = 2'h3;
    localparam logic [1:0] PRE_DIV1     = 2'h0;
    localparam logic [1:0] PRE_DIV16    = 2'h1;
    localparam logic [1:0] PRE_DIV256   = 2'h2;

    // Prescaler terminal counts (ratio minus one)
    localparam logic [14:0] TERM_DIV1      = 15'h0000;
    localparam logic [14:0] TERM_DIV4      = 15'h0003;
    localparam logic [14:0] TERM_DIV16     = 15'h000F;
    localparam logic [14:0] TERM_DIV256    = 15'h00FF;
    localparam logic [14:0] divide_by_32768 = 15'h7FFF;

    // Interrupt flag positions and status layout
    localparam int IRQ_N      = 5;
    localparam int IRQ_A      = 0;
    localparam int IRQ_B      = 1;
    localparam int IRQ_C      = 2;
    localparam int IRQ_D      = 3;
    localparam int IRQ_FULL   = 4;
    localparam int STA_BUSY   = 6;
    localparam int SHIFT_A    = 5;
    localparam logic [1:0] CLR_OSC_EDGES = 2'h2;

    // Reset values
    localparam logic [15:0] CTL_RESET      = 16'h0040;
    localparam logic [11:0] INTERVAL_RESET = 12'h0C8;
    localparam logic [31:0] CMP_A_RESET    = 32'h0000_1900;
    localparam logic [31:0] CMP_B_RESET    = 32'h0000_1FFF;
    localparam logic [31:0] CMP_C_RESET    = 32'h0000_2FFF;
    localparam logic [31:0] CMP_D_RESET    = 32'h0000_3FFF;
    localparam logic [31:0] ALL_ONES       = 32'hFFFF_FFFF;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Master to slave signals
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axi_req_s;

    // Slave to master signals
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_s;

    // Complete block state
    typedef struct packed {
        logic [15:0]       control;
        logic [11:0]       interval;
        logic [31:0]       cmp_a;
        logic [31:0]       cmp_b;
        logic [31:0]       cmp_c;
        logic [31:0]       cmp_d;
        logic [IRQ_N-1:0]  irq_en;
        logic [IRQ_N-1:0]  irq_flag;
        logic [IRQ_N-1:0]  clr_pend;
        logic              clr_busy;
        logic [1:0]        clr_edges;
        logic [31:0]       count;
        logic [14:0]       pre_count;
        logic [15:0]       high_hold;
        logic              frozen;
        logic              osc_meta;
        logic              osc_sync;
        logic              osc_prev;
        logic              ext_meta;
        logic              ext_sync;
        logic              ext_prev;
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              irq;
    } state_s;

    localparam state_s STATE_RESET = '{
        control:  CTL_RESET,
        interval: INTERVAL_RESET,
        cmp_a:    CMP_A_RESET,
        cmp_b:    CMP_B_RESET,
        cmp_c:    CMP_C_RESET,
        cmp_d:    CMP_D_RESET,
        default:  '0
    };

endpackage : wake_timer_pkg

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the wake-up timer
// Assumes: Peripheral and oscillator sources; external pin held low
// Notes:   Bus tasks keep requests until taken
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wake_timer_pkg::*;
    logic        clock, reset_n, clock_enable, pclk_on, irq, osc;
    axi_req_s    bus_req;
    axi_rsp_s    bus_rsp;
    int          miscompares = 0, checks = 0, n;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    // External pin tied low; the oscillator is toggled by the bench
    wake_timer wake_timer_i (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .pclk_on(pclk_on),
        .low_freq_osc(osc), .external_clock_pin(1'b0), .bus_req(bus_req), .bus_rsp(bus_rsp), .irq(irq));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // Both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic aw_left, w_left;
        @(posedge clock);
        bus_req.awvalid <= 1'b1;
        bus_req.awaddr  <= a;
        bus_req.wvalid  <= 1'b1;
        bus_req.wdata   <= {16'h0000, d};
        bus_req.wstrb   <= 4'hF;
        bus_req.bready  <= 1'b1;
        aw_left = 1'b1;
        w_left  = 1'b1;
        while (aw_left || w_left) begin
            @(posedge clock);
            if (bus_rsp.awready) aw_left = 1'b0;
            if (bus_rsp.wready) w_left = 1'b0;
            bus_req.awvalid <= aw_left;
            bus_req.wvalid  <= w_left;
        end
        do @(posedge clock); while (bus_rsp.bvalid !== 1'b1);
        bus_req.bready <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus_req.arvalid <= 1'b1;
        bus_req.araddr  <= a;
        bus_req.rready  <= 1'b1;
        do @(posedge clock); while (bus_rsp.arready !== 1'b1);
        bus_req.arvalid <= 1'b0;
        do @(posedge clock); while (bus_rsp.rvalid !== 1'b1);
        rd_data = bus_rsp.rdata;
        rd_resp = bus_rsp.rresp;
        bus_req.rready <= 1'b0;
        check(rd_data, exp);
    endtask : rchk
    // Bounded wait for the interrupt line
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        check({31'h0, irq}, 32'h1);
    endtask : wait_irq
    task automatic reset_values;
        rchk(OFF_CONTROL, 32'h0040);
        rchk(OFF_INTERVAL, 32'h00C8);
        rchk(OFF_CMP_A_LOW, 32'h1900);
        rchk(OFF_CMP_D_LOW, 32'h3FFF);
        rchk(8'h80, 32'h0);
        check({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    endtask : reset_values
    // Periodic count to 3 at one step per four cycles
    task automatic periodic_run;
        wr(OFF_CMP_D_LOW, 16'h0003);
        wr(OFF_IRQ_ENABLE, 16'h0008);
        wr(OFF_CONTROL, 16'h0080);
        wait_irq;
        check({31'h0, n >= 14 && n <= 24}, 32'h1);
        rchk(OFF_STATUS, 32'h0008);
        wr(OFF_CONTROL, 16'h0000);
        rchk(OFF_COUNT_LOW, 32'h0);
        wr(OFF_IRQ_CLEAR, 16'h0008);
        rchk(OFF_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask : periodic_run
    // Interval load, hardware advance, then advance blocked
    task automatic auto_advance;
        wr(OFF_CMP_B_LOW, 16'h0050);
        wr(OFF_INTERVAL, 16'h0001);
        rchk(OFF_CMP_A_LOW, 32'h0020);
        wr(OFF_IRQ_ENABLE, 16'h0001);
        wr(OFF_CONTROL, 16'h00C0);
        wait_irq;
        rchk(OFF_CMP_A_LOW, 32'h0040);
        wr(OFF_CONTROL, 16'h08C0);
        wr(OFF_INTERVAL, 16'h0003);
        repeat (300) @(posedge clock);
        rchk(OFF_CMP_A_LOW, 32'h0040);
    endtask : auto_advance
    // Oscillator clear needs two slow edges; a short freeze first
    task automatic osc_clear;
        wr(OFF_CONTROL, 16'h0200);
        wr(OFF_IRQ_CLEAR, 16'h0001);
        rchk(OFF_STATUS, 32'h004B);
        clock_enable <= 1'b0;
        repeat (3) @(posedge clock);
        clock_enable <= 1'b1;
        repeat (4) begin
            repeat (8) @(posedge clock);
            osc <= ~osc;
        end
        rchk(OFF_STATUS, 32'h000A);
        check({31'h0, irq}, 32'h0);
    endtask : osc_clear
    initial begin
        clock_enable = 1'b1;
        pclk_on = 1'b1;
        osc = 1'b0;
        bus_req = '0;
        reset_n = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        reset_values;
        periodic_run;
        auto_advance;
        osc_clear;
        close_out;
    end
    // Watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule : testbench

// ===== tb/wake_timer_sva.sv
// Purpose: Port-level checks of the wake-up timer
// Assumes: One clock domain, async active-low reset
// Notes:   Bound into the top module
module wake_timer_sva
    import wake_timer_pkg::*;
(
    // Clock and reset
    input wire logic                     clock,
    input wire logic                     reset_n,
    // Watched ports
    input wire logic                     clock_enable,
    input wire wake_timer_pkg::axi_req_s bus_req,
    input wire wake_timer_pkg::axi_rsp_s bus_rsp,
    input wire logic                     irq
);
    import wake_timer_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_READ_NEXT: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property (bus_rsp.rvalid && !bus_req.rready |=> $stable(bus_rsp.rdata))
        else $error("read data moved");
    AST_READ_UPPER: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_ERR_ZERO: assert property (bus_rsp.rvalid && bus_rsp.rresp == RESP_SLVERR |-> bus_rsp.rdata == 32'h0)
        else $error("error read not zero");
    AST_WRITE_RESP: assert property (bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready
        |-> ##[1:2] bus_rsp.bvalid) else $error("write answer late");
    AST_WRITE_HOLD: assert property (bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid)
        else $error("write answer dropped");
    AST_NO_AR: assert property (bus_rsp.rvalid |-> !bus_rsp.arready)
        else $error("second read taken");
    AST_FROZEN: assert property (!clock_enable |-> !(bus_rsp.awready || bus_rsp.wready))
        else $error("ready while frozen");
    AST_IRQ_RESET: assert property ($rose(reset_n) |-> !irq)
        else $error("irq out of reset");
endmodule : wake_timer_sva

bind wake_timer wake_timer_sva wake_timer_sva_i (.clock(clock), .reset_n(reset_n),
    .clock_enable(clock_enable), .bus_req(bus_req), .bus_rsp(bus_rsp), .irq(irq));
